// ==== logic/shl_regs.sv ====
/*
 * Host link register bank: ROM window base and address forming,
 * failed posted write capture, vendor register, controller flags,
 * node report pointer and counters, receive channel masks.
 * Assumes a one-cycle register strobe interface, synchronous to ref_clk.
 */
//
// Functional notes
// - ROM window read address is base bits 31:10 plus low ten offset bits.
// - Failed posted write captures low 32 destination offset bits, read-only.
// - High capture holds requester in 31:16, upper offset bits in 15:0.
// - Vendor register is read-only fixed value; writes ignored.
// - Controller flags use set view at 50h, clear view at 54h.
// - Set view ones set, clear view ones clear, zeros leave bits.
// - Bit 30 selects byte swapping of DMA data.
// - Bit 23 ownership loads from EEPROM, software may only clear it.
// - Bit 19 zero blocks link-to-PHY communication.
// - Bit 18 enables posted writes.
// - Link enable clears on resets; zero disconnects from bus.
// - Soft reset reinitialises state, flushes FIFOs, resets registers.
// - Soft reset bit reads one while in progress, then zero.
// - Report pointer 2 Kbyte aligned; bits 31:11 writable, rest zero.
// - Count bit 31 flags latest reception error, clears on clean one.
// - Generation field increments per bus reset, wraps after 255.
// - Size field counts quadlets written, clears when reception begins.
// - Upper channel mask pair at 70h/74h, bit n is channel n+32.
// - Lower channel mask pair at 78h/7Ch, channels 0 to 31.
`timescale 1ns/1ps

module shl_regs
	import shl_pkg::*;
(
	input  wire logic        ref_clk,        // System clock
	input  wire logic        rst,            // Synchronous reset, high
	input  wire shl_bus_s    bus,            // Register access strobe
	output logic [31:0]      rdata,          // Read data, one cycle later
	output logic             rvalid,         // Read data valid pulse
	input  wire logic        eeprom_load,    // EEPROM load strobe
	input  wire logic        eeprom_owner,   // EEPROM ownership value
	input  wire logic        rom_rd,         // ROM window read request
	input  wire logic [47:0] rom_offset,     // Bus offset of that read
	output logic [31:0]      rom_host_addr,  // Formed host address
	output logic             rom_addr_valid, // Address valid pulse
	input  wire shl_fail_s   fail,           // Failed posted write report
	input  wire shl_report_s report,         // Node report events
	output logic             swap_select,    // Byte swap control
	output logic             enhanced_features_on, // Enhanced PHY features
	output logic             phy_comm_allow, // Link-to-PHY allowed
	output logic             write_posting_on, // Posted writes enabled
	output logic             node_online,    // Connected to bus
	output logic             local_reinit,   // Flush and reset, held high through soft reset
	output logic [31:0]      upper_channel_mask, // Channels 63..32
	output logic [31:0]      lower_channel_mask  // Channels 31..0
);

	////////////////////////////////////////////////////////////////////
	// Decode helpers

	// One address compare used by every write path
	function automatic logic hit(input shl_bus_s b, input logic [7:0] ofs);
		hit = b.wr && (b.addr == ofs);
	endfunction

	// Set/clear update shared by all pairs
	function automatic logic [31:0] set_clear(input logic [31:0] cur,
			input logic [31:0] s, input logic [31:0] c);
		set_clear = (cur | s) & ~c;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	logic [31:0] rom_base, next_rom_base;
	logic [31:0] fail_low, next_fail_low;
	logic [31:0] fail_high, next_fail_high;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] report_ptr, next_report_ptr;
	logic        report_fault, next_report_fault;
	logic [7:0]  generation, next_generation;
	logic [8:0]  quadlets, next_quadlets;
	logic [31:0] upper_mask, next_upper_mask;
	logic [31:0] lower_mask, next_lower_mask;
	shl_reinit_e rstate, next_rstate;
	logic [3:0]  rcount, next_rcount;
	logic [31:0] next_rdata;
	logic        next_rvalid;
	logic [31:0] next_rom_host_addr;
	logic        next_rom_addr_valid;
	logic        clr_all;

	// Soft reset returns registers to hardware values too
	assign clr_all = rst || (rstate == RS_BUSY);

	////////////////////////////////////////////////////////////////////
	// Soft reset sequencer

	// Holds the reinit for a fixed time so downstream FIFOs can drain
	always_comb begin
		next_rstate = rstate;
		next_rcount = rcount;
		case (rstate)
			RS_IDLE: begin
				if (hit(bus, OFS_CTRL_SET) && bus.wdata[BIT_REINIT]) begin
					next_rstate = RS_BUSY;
					next_rcount = REINIT_LOAD;
				end
			end
			RS_BUSY: begin
				next_rcount = rcount - 4'h1;
				if (rcount == 4'h1) begin
					next_rstate = RS_IDLE;
				end
			end
			default: begin
				next_rstate = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rstate <= RS_IDLE;
			rcount <= 4'h0;
		end else begin
			rstate <= next_rstate;
			rcount <= next_rcount;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Controller flags

	// Ownership only clears from software; EEPROM may load it
	always_comb begin
		logic [31:0] s;
		logic [31:0] c;
		s = ZERO_WORD;
		c = ZERO_WORD;
		if (hit(bus, OFS_CTRL_SET)) begin
			s = bus.wdata & CTRL_SET_MASK;
		end
		if (hit(bus, OFS_CTRL_CLR)) begin
			c = bus.wdata & CTRL_CLR_MASK;
		end
		s[BIT_REINIT] = 1'b0;
		next_ctrl = set_clear(ctrl, s, c);
		if (eeprom_load) begin
			next_ctrl[BIT_OWNER] = eeprom_owner;
		end
		next_ctrl[BIT_REINIT] = (next_rstate == RS_BUSY);
		if (clr_all && !(rstate == RS_IDLE && next_rstate == RS_BUSY)) begin
			next_ctrl = CTRL_RESET;
			next_ctrl[BIT_REINIT] = (next_rstate == RS_BUSY);
		end
		if (rst) begin
			next_ctrl = CTRL_RESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		ctrl <= next_ctrl;
	end

	////////////////////////////////////////////////////////////////////
	// ROM base, pointer, channel masks

	always_comb begin
		next_rom_base   = rom_base;
		next_report_ptr = report_ptr;
		if (hit(bus, OFS_ROM_BASE)) begin
			next_rom_base = bus.wdata & ROM_BASE_MASK;
		end
		if (hit(bus, OFS_REPORT_PTR)) begin
			next_report_ptr = bus.wdata & PTR_MASK;
		end
		next_upper_mask = set_clear(upper_mask,
			hit(bus, OFS_UPPER_SET) ? bus.wdata : ZERO_WORD,
			hit(bus, OFS_UPPER_CLR) ? bus.wdata : ZERO_WORD);
		next_lower_mask = set_clear(lower_mask,
			hit(bus, OFS_LOWER_SET) ? bus.wdata : ZERO_WORD,
			hit(bus, OFS_LOWER_CLR) ? bus.wdata : ZERO_WORD);
		if (clr_all) begin
			next_rom_base   = ZERO_WORD;
			next_report_ptr = ZERO_WORD;
			next_upper_mask = MASK_RESET;
			next_lower_mask = MASK_RESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		rom_base   <= next_rom_base;
		report_ptr <= next_report_ptr;
		upper_mask <= next_upper_mask;
		lower_mask <= next_lower_mask;
	end

	////////////////////////////////////////////////////////////////////
	// Failed posted write capture

	// Capture only while posting is on; software cannot write these
	always_comb begin
		next_fail_low  = fail_low;
		next_fail_high = fail_high;
		if (fail.fail && ctrl[BIT_POSTING]) begin
			next_fail_low  = fail.dest[31:0];
			next_fail_high = {fail.requester, fail.dest[47:32]};
		end
		if (clr_all) begin
			next_fail_low  = ZERO_WORD;
			next_fail_high = ZERO_WORD;
		end
	end

	always_ff @(posedge ref_clk) begin
		fail_low  <= next_fail_low;
		fail_high <= next_fail_high;
	end

	////////////////////////////////////////////////////////////////////
	// Node report counters

	// Events ignored while offline, since no packets are received then
	always_comb begin
		next_report_fault = report_fault;
		next_generation   = generation;
		next_quadlets     = quadlets;
		if (ctrl[BIT_ONLINE]) begin
			if (report.bus_reset) begin
				next_generation = (generation == GEN_MAX) ? 8'h00
					: generation + GEN_ONE;
			end
			if (report.begin_rx) begin
				next_quadlets = 9'h000;
			end else if (report.quadlet) begin
				next_quadlets = quadlets + SIZE_ONE;
			end
			if (report.done) begin
				next_report_fault = report.error;
			end
		end
		if (clr_all) begin
			next_report_fault = 1'b0;
			next_generation   = 8'h00;
			next_quadlets     = 9'h000;
		end
	end

	always_ff @(posedge ref_clk) begin
		report_fault <= next_report_fault;
		generation   <= next_generation;
		quadlets     <= next_quadlets;
	end

	////////////////////////////////////////////////////////////////////
	// ROM window address forming

	// One cycle latency; out-of-window offsets give no valid pulse
	always_comb begin
		next_rom_addr_valid = 1'b0;
		next_rom_host_addr  = rom_host_addr;
		if (rom_rd && node_online && rom_offset >= ROM_WIN_LO
				&& rom_offset <= ROM_WIN_HI) begin
			next_rom_addr_valid = 1'b1;
			next_rom_host_addr  = rom_base
				+ {22'h0, rom_offset[ROM_OFS_BITS-1:0]};
		end
		if (rst) begin
			next_rom_addr_valid = 1'b0;
			next_rom_host_addr  = ZERO_WORD;
		end
	end

	always_ff @(posedge ref_clk) begin
		rom_addr_valid <= next_rom_addr_valid;
		rom_host_addr  <= next_rom_host_addr;
	end

	////////////////////////////////////////////////////////////////////
	// Read mux

	// Both views of each pair return the stored value
	always_comb begin
		next_rvalid = bus.rd && !rst;
		next_rdata  = ZERO_WORD;
		if (bus.addr == OFS_ROM_BASE) begin
			next_rdata = rom_base;
		end else if (bus.addr == OFS_FAIL_LOW) begin
			next_rdata = fail_low;
		end else if (bus.addr == OFS_FAIL_HIGH) begin
			next_rdata = fail_high;
		end else if (bus.addr == OFS_VENDOR) begin
			next_rdata = VENDOR_VALUE;
		end else if (bus.addr == OFS_CTRL_SET || bus.addr == OFS_CTRL_CLR) begin
			next_rdata = ctrl;
		end else if (bus.addr == OFS_REPORT_PTR) begin
			next_rdata = report_ptr;
		end else if (bus.addr == OFS_REPORT_CNT) begin
			next_rdata = ZERO_WORD;
			next_rdata[CNT_ERR_BIT] = report_fault;
			next_rdata[GEN_LSB +: 8] = generation;
			next_rdata[SIZE_LSB +: 9] = quadlets;
		end else if (bus.addr == OFS_UPPER_SET || bus.addr == OFS_UPPER_CLR) begin
			next_rdata = upper_mask;
		end else if (bus.addr == OFS_LOWER_SET || bus.addr == OFS_LOWER_CLR) begin
			next_rdata = lower_mask;
		end
		if (!bus.rd || rst) begin
			next_rdata = ZERO_WORD;
		end
	end

	always_ff @(posedge ref_clk) begin
		rdata  <= next_rdata;
		rvalid <= next_rvalid;
	end

	////////////////////////////////////////////////////////////////////
	// Control outputs, registered

	always_ff @(posedge ref_clk) begin
		swap_select          <= next_ctrl[BIT_SWAP];
		enhanced_features_on <= next_ctrl[BIT_ENHANCE];
		phy_comm_allow       <= next_ctrl[BIT_LPS];
		write_posting_on     <= next_ctrl[BIT_POSTING];
		node_online          <= next_ctrl[BIT_ONLINE];
		local_reinit         <= next_ctrl[BIT_REINIT];
		upper_channel_mask   <= next_upper_mask;
		lower_channel_mask   <= next_lower_mask;
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_reinit_req;
		bus.wr && bus.addr == OFS_CTRL_SET && bus.wdata[BIT_REINIT] && rstate == RS_IDLE;
	endsequence

	a_reinit_reads_one: assert property (@(posedge ref_clk) disable iff (rst)
		s_reinit_req |=> ctrl[BIT_REINIT] [*2])
		else $error("soft reset bit not held during reset");
	a_reinit_ends: assert property (@(posedge ref_clk) disable iff (rst)
		s_reinit_req |-> ##8 ctrl[BIT_REINIT] ##1 !ctrl[BIT_REINIT])
		else $error("soft reset bit did not clear");
	a_online_cleared: assert property (@(posedge ref_clk) disable iff (rst)
		s_reinit_req |=> ##1 !ctrl[BIT_ONLINE])
		else $error("link enable survived soft reset");
	a_ctrl_set_works: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == OFS_CTRL_SET && bus.wdata[BIT_LPS] && rstate == RS_IDLE
		&& !bus.wdata[BIT_REINIT]) |=> ctrl[BIT_LPS])
		else $error("set view did not set");
	a_ctrl_clr_works: assert property (@(posedge ref_clk) disable iff (rst)
		(bus.wr && bus.addr == OFS_CTRL_CLR && bus.wdata[BIT_SWAP]) |=> !ctrl[BIT_SWAP])
		else $error("clear view did not clear");
	a_owner_no_set: assert property (@(posedge ref_clk) disable iff (rst)
		(!ctrl[BIT_OWNER] && !eeprom_load) |=> !ctrl[BIT_OWNER])
		else $error("ownership set by software");
	a_ptr_aligned: assert property (@(posedge ref_clk) disable iff (rst)
		report_ptr[10:0] == 11'h000)
		else $error("report pointer low bits not zero");
	a_gen_wraps: assert property (@(posedge ref_clk) disable iff (rst)
		(report.bus_reset && ctrl[BIT_ONLINE] && rstate == RS_IDLE
		&& !(bus.wr && bus.addr == OFS_CTRL_SET && bus.wdata[BIT_REINIT]))
		|=> generation == $past(generation) + GEN_ONE)
		else $error("generation did not advance");
	a_fail_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(fail.fail && ctrl[BIT_POSTING] && rstate == RS_IDLE
		&& !(bus.wr && bus.addr == OFS_CTRL_SET && bus.wdata[BIT_REINIT]))
		|=> fail_low == $past(fail.dest[31:0]))
		else $error("failed write offset not captured");
	a_rom_addr: assert property (@(posedge ref_clk) disable iff (rst)
		rom_addr_valid |-> rom_host_addr[9:0] == $past(rom_offset[9:0]) + $past(rom_base[9:0]))
		else $error("ROM host address wrong");

endmodule

// ==== include/shl_pkg.sv ====
/*
 * Package for the host link register bank: offsets, field positions,
 * reset values, timing counts and the carrier structs.
 * Assumes a single 125 MHz clock domain.
 */
package shl_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_ROM_BASE    = 8'h34;
	localparam logic [7:0] OFS_FAIL_LOW    = 8'h38;
	localparam logic [7:0] OFS_FAIL_HIGH   = 8'h3C;
	localparam logic [7:0] OFS_VENDOR      = 8'h40;
	localparam logic [7:0] OFS_CTRL_SET    = 8'h50;
	localparam logic [7:0] OFS_CTRL_CLR    = 8'h54;
	localparam logic [7:0] OFS_REPORT_PTR  = 8'h64;
	localparam logic [7:0] OFS_REPORT_CNT  = 8'h68;
	localparam logic [7:0] OFS_UPPER_SET   = 8'h70;
	localparam logic [7:0] OFS_UPPER_CLR   = 8'h74;
	localparam logic [7:0] OFS_LOWER_SET   = 8'h78;
	localparam logic [7:0] OFS_LOWER_CLR   = 8'h7C;

	// Control flag positions
	localparam int BIT_SWAP     = 30;
	localparam int BIT_OWNER    = 23;
	localparam int BIT_ENHANCE  = 22;
	localparam int BIT_LPS      = 19;
	localparam int BIT_POSTING  = 18;
	localparam int BIT_ONLINE   = 17;
	localparam int BIT_REINIT   = 16;

	// Writable masks
	localparam logic [31:0] CTRL_SET_MASK  = 32'h404F_0000;
	localparam logic [31:0] CTRL_CLR_MASK  = 32'h40CE_0000;
	localparam logic [31:0] ROM_BASE_MASK  = 32'hFFFF_FC00;
	localparam logic [31:0] PTR_MASK       = 32'hFFFF_F800;
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

	// Reset values
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET     = 32'h0000_0000;

	// ROM window: upper 38 offset bits of 48'hFFFF_F000_0400..07FF
	localparam logic [47:0] ROM_WIN_LO     = 48'hFFFF_F000_0400;
	localparam logic [47:0] ROM_WIN_HI     = 48'hFFFF_F000_07FF;
	localparam int          ROM_OFS_BITS   = 10;

	// Count register fields
	localparam int          CNT_ERR_BIT    = 31;
	localparam int          GEN_LSB        = 16;
	localparam int          SIZE_LSB       = 2;
	localparam logic [7:0]  GEN_MAX        = 8'hFF;
	localparam logic [8:0]  SIZE_ONE       = 9'h001;
	localparam logic [7:0]  GEN_ONE        = 8'h01;

	// Local reinit duration
	localparam int REINIT_NS      = 64;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int REINIT_CYCLES  = (REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] REINIT_LOAD = 4'(REINIT_CYCLES);

	// Arbitrary neutral vendor value
	localparam logic [31:0] VENDOR_VALUE   = 32'h0000_0000;

	// Register access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} shl_bus_s;

	// Failed posted write report
	typedef struct packed {
		logic        fail;
		logic [15:0] requester;
		logic [47:0] dest;
	} shl_fail_s;

	// Node report reception events
	typedef struct packed {
		logic        bus_reset;
		logic        begin_rx;
		logic        quadlet;
		logic        done;
		logic        error;
	} shl_report_s;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b01,
		RS_BUSY = 2'b10
	} shl_reinit_e;

endpackage

// ==== sim/tb.sv ====
/*
 * Self-checking bench for the host link register bank, with a behavioural
 * register model kept in the bench.
 * Assumes shl_pkg and shl_regs are compiled first; the bench drives every port.
 */
`timescale 1ns/1ps

module tb
	import shl_pkg::*;
;

	localparam logic [4:0]  EV_RST   = 5'b10000;
	localparam logic [4:0]  EV_BEGIN = 5'b01000;
	localparam logic [4:0]  EV_QUAD  = 5'b00100;
	localparam logic [4:0]  EV_OK    = 5'b00010;
	localparam logic [4:0]  EV_ERR   = 5'b00011;
	localparam int          CEILING  = 5000;
	localparam logic [7:0]  ADDRS [14] = '{8'h00, OFS_ROM_BASE, OFS_FAIL_LOW, OFS_FAIL_HIGH,
		OFS_VENDOR, 8'h44, OFS_CTRL_SET, OFS_CTRL_CLR, OFS_REPORT_PTR, OFS_REPORT_CNT,
		OFS_UPPER_SET, OFS_UPPER_CLR, OFS_LOWER_SET, OFS_LOWER_CLR};

	logic        ref_clk = 1'b0;
	logic        rst;
	shl_bus_s    bus;
	logic [31:0] rdata;
	logic        rvalid;
	logic        eeprom_load;
	logic        eeprom_owner;
	logic        rom_rd;
	logic [47:0] rom_offset;
	logic [31:0] rom_host_addr;
	logic        rom_addr_valid;
	shl_fail_s   fail;
	logic [4:0]  report;
	logic        swap_select;
	logic        enhanced_features_on;
	logic        phy_comm_allow;
	logic        write_posting_on;
	logic        node_online;
	logic        local_reinit;
	logic [31:0] upper_channel_mask;
	logic [31:0] lower_channel_mask;

	// Model state, written from the register descriptions
	logic [31:0] m_rom, m_flo, m_fhi, m_ctrl, m_ptr, m_um, m_lm;
	int          m_gen, m_size;
	logic        m_err;
	int          errors, checks, cycles;
	logic [31:0] seed;

	shl_regs shl_regs_i (
		.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .rvalid(rvalid),
		.eeprom_load(eeprom_load), .eeprom_owner(eeprom_owner), .rom_rd(rom_rd),
		.rom_offset(rom_offset), .rom_host_addr(rom_host_addr),
		.rom_addr_valid(rom_addr_valid), .fail(fail), .report(report),
		.swap_select(swap_select), .enhanced_features_on(enhanced_features_on),
		.phy_comm_allow(phy_comm_allow), .write_posting_on(write_posting_on),
		.node_online(node_online), .local_reinit(local_reinit),
		.upper_channel_mask(upper_channel_mask), .lower_channel_mask(lower_channel_mask)
	);

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// Hang guard; counts as a mismatch
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == CEILING) begin
			errors++;
			finish_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
	endfunction

	// Expected read value of each offset
	function automatic logic [31:0] mread(input logic [7:0] a);
		case (a)
			OFS_ROM_BASE:                 return m_rom;
			OFS_FAIL_LOW:                 return m_flo;
			OFS_FAIL_HIGH:                return m_fhi;
			OFS_VENDOR:                   return VENDOR_VALUE;
			OFS_CTRL_SET, OFS_CTRL_CLR:   return m_ctrl;
			OFS_REPORT_PTR:               return m_ptr;
			OFS_REPORT_CNT:               return {m_err, 7'h00, 8'(m_gen), 5'h00, 9'(m_size), 2'b00};
			OFS_UPPER_SET, OFS_UPPER_CLR: return m_um;
			OFS_LOWER_SET, OFS_LOWER_CLR: return m_lm;
			default:                      return ZERO_WORD;
		endcase
	endfunction

	task automatic finish_test();
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write strobe, then the model follows
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		#1;
		case (a)
			OFS_ROM_BASE:   m_rom = d & ROM_BASE_MASK;
			OFS_CTRL_SET:   m_ctrl = m_ctrl | (d & CTRL_SET_MASK);
			OFS_CTRL_CLR:   m_ctrl = m_ctrl & ~(d & CTRL_CLR_MASK);
			OFS_REPORT_PTR: m_ptr = d & PTR_MASK;
			OFS_UPPER_SET:  m_um = m_um | d;
			OFS_UPPER_CLR:  m_um = m_um & ~d;
			OFS_LOWER_SET:  m_lm = m_lm | d;
			OFS_LOWER_CLR:  m_lm = m_lm & ~d;
			default:        ;
		endcase
	endtask

	// Read data is registered: looked at once the sampling edge has landed
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		chk("rvalid", 32'h0000_0001, {31'h0, rvalid});
		chk($sformatf("reg %h", a), mread(a), rdata);
	endtask

	task automatic rd_all();
		for (int i = 0; i < 14; i++) begin
			rd(ADDRS[i]);
		end
	endtask

	task automatic chk_out();
		chk("ctrl outputs", {26'h0, m_ctrl[30], m_ctrl[22], m_ctrl[19], m_ctrl[18], m_ctrl[17],
			m_ctrl[16]}, {26'h0, swap_select, enhanced_features_on, phy_comm_allow,
			write_posting_on, node_online, local_reinit});
		chk("upper mask", m_um, upper_channel_mask);
		chk("lower mask", m_lm, lower_channel_mask);
	endtask

	// Node report event pulse; counters move only while online
	task automatic ev(input logic [4:0] v);
		@(posedge ref_clk);
		report <= v;
		@(posedge ref_clk);
		report <= 5'h00;
		#1;
		if (m_ctrl[17]) begin
			if (v[4]) m_gen = (m_gen + 1) % 256;
			if (v[3]) m_size = 0;
			if (v[2]) m_size++;
			if (v[1]) m_err = v[0];
		end
	endtask

	// Failed posted write report, kept only while posting is on
	task automatic fl(input logic [15:0] q, input logic [47:0] d);
		@(posedge ref_clk);
		fail <= '{fail: 1'b1, requester: q, dest: d};
		@(posedge ref_clk);
		fail.fail <= 1'b0;
		#1;
		if (m_ctrl[18]) begin
			m_flo = d[31:0];
			m_fhi = {q, d[47:32]};
		end
	endtask

	task automatic rom(input logic [47:0] off);
		logic hit;
		hit = m_ctrl[17] && off >= ROM_WIN_LO && off <= ROM_WIN_HI;
		@(posedge ref_clk);
		rom_rd <= 1'b1;
		rom_offset <= off;
		@(posedge ref_clk);
		rom_rd <= 1'b0;
		#1;
		chk("rom valid", {31'h0, hit}, {31'h0, rom_addr_valid});
		if (hit) chk("rom addr", (m_rom & ROM_BASE_MASK) + 32'(off[9:0]), rom_host_addr);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] a;
		bus = '0; eeprom_load = 1'b0; eeprom_owner = 1'b0; rom_rd = 1'b0;
		rom_offset = '0; fail = '0; report = 5'h00; rst = 1'b1;
		m_rom = 0; m_flo = 0; m_fhi = 0; m_ctrl = 0; m_ptr = 0; m_um = 0; m_lm = 0;
		m_gen = 0; m_size = 0; m_err = 1'b0; errors = 0; checks = 0; cycles = 0;
		seed = 32'h0001_2239;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		rd_all();
		chk_out();
		// Read-only places must shrug off writes
		for (int i = 0; i < 14; i++) begin
			if (ADDRS[i] inside {OFS_FAIL_LOW, OFS_FAIL_HIGH, OFS_VENDOR, OFS_REPORT_CNT}) begin
				wr(ADDRS[i], 32'hFFFF_FFFF);
			end
		end
		seed = lfsr(seed);
		wr(OFS_ROM_BASE, seed);
		seed = lfsr(seed);
		wr(OFS_REPORT_PTR, seed);
		wr(8'h44, seed);
		rd_all();
		fl(16'hFFC1, 48'hABCD_1234_5678);
		rd(OFS_FAIL_LOW);
		// Controller flags through both views
		wr(OFS_CTRL_SET, 32'h4088_0000);
		chk_out();
		@(posedge ref_clk);
		eeprom_load <= 1'b1;
		eeprom_owner <= 1'b1;
		@(posedge ref_clk);
		eeprom_load <= 1'b0;
		#1;
		m_ctrl[23] = 1'b1;
		rd(OFS_CTRL_SET);
		wr(OFS_CTRL_SET, 32'h0004_0000);
		wr(OFS_CTRL_SET, 32'h0002_0000);
		ev(EV_RST);
		wr(OFS_CTRL_SET, 32'h0040_0000);
		wr(OFS_CTRL_CLR, 32'h0001_0000);
		wr(OFS_CTRL_CLR, 32'h0000_0000);
		rd(OFS_CTRL_CLR);
		chk_out();
		wr(OFS_CTRL_CLR, 32'h4080_0000);
		rd(OFS_CTRL_SET);
		chk_out();
		// Channel masks, random set and clear, read through the other view
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			a = OFS_UPPER_SET + {4'h0, seed[1:0], 2'b00};
			wr(a, lfsr(seed));
			rd(a ^ 8'h04);
			chk_out();
		end
		// ROM window forming, edges of the window and just outside
		seed = lfsr(seed);
		rom(ROM_WIN_LO + 48'(seed[9:0]));
		rom(ROM_WIN_LO);
		rom(ROM_WIN_HI);
		rom(ROM_WIN_LO - 48'h4);
		rom(ROM_WIN_HI + 48'h1);
		seed = lfsr(seed);
		fl(seed[31:16], {seed[15:0], lfsr(seed)});
		rd(OFS_FAIL_LOW);
		rd(OFS_FAIL_HIGH);
		// Node report: faulty reception, then a clean one
		ev(EV_BEGIN);
		repeat (seed[3:0] + 1) ev(EV_QUAD);
		ev(EV_ERR);
		rd(OFS_REPORT_CNT);
		ev(EV_BEGIN);
		rd(OFS_REPORT_CNT);
		repeat (seed[7:4] + 2) ev(EV_QUAD);
		ev(EV_OK);
		rd(OFS_REPORT_CNT);
		repeat (254) ev(EV_RST);
		rd(OFS_REPORT_CNT);
		ev(EV_RST);
		rd(OFS_REPORT_CNT);
		// Offline: no ROM forming and no report counting
		wr(OFS_CTRL_CLR, 32'h0002_0000);
		chk_out();
		rom(ROM_WIN_LO);
		ev(EV_RST);
		rd(OFS_REPORT_CNT);
		// Local reinit: bit reads one while running, then all back to reset values
		wr(OFS_CTRL_SET, 32'h400B_0000);
		m_rom = 0; m_flo = 0; m_fhi = 0; m_ptr = 0; m_um = 0; m_lm = 0;
		m_gen = 0; m_size = 0; m_err = 1'b0; m_ctrl = 32'h0001_0000;
		rd(OFS_CTRL_SET);
		chk("reinit", 32'h0000_0001, {31'h0, local_reinit});
		repeat (12) @(posedge ref_clk);
		#1;
		m_ctrl = 32'h0000_0000;
		rd_all();
		chk_out();
		finish_test();
	end

endmodule
